// ==== bco_params.svh ====
`ifndef BCO_PARAMS_SVH
`define BCO_PARAMS_SVH
`define BCO_CLK_HZ        10000000
`define BCO_MS_PER_S      1000
`define BCO_TICK_CYCLES   (`BCO_CLK_HZ / `BCO_MS_PER_S)
`define BCO_PULSE_MIN_MS  16'h0032
`define BCO_PULSE_MAX_MS  16'h03E8
`define BCO_PULSE_DEF_MS  16'h012C
`define BCO_EARLY_MIN_MS  16'h0064
`define BCO_OPER_MS       16'h0096
`define BCO_SYNC_DEF_MS   16'h03E8
`define BCO_SW_DEF_MS     16'h0000
`define BCO_FILT_DEF_MS   16'h0014
`define BCO_MS_ZERO       16'h0000
`define BCO_MS_ONE        16'h0001
`endif

// ==== bco_pkg.sv ====
package bco_pkg;
  typedef enum logic [1:0] {
    BCO_ST_MID = 2'b00,
    BCO_ST_OFF = 2'b01,
    BCO_ST_ON  = 2'b10,
    BCO_ST_BAD = 2'b11
  } bco_state_t;

  typedef struct packed {
    logic       valid;
    logic       value;
  } bco_oper_t;

  typedef struct packed {
    logic       strobe;
    bco_state_t value;
  } bco_event_t;
endpackage

// ==== bco_ms_timer.sv ====
`timescale 1ns/1ps
`include "bco_params.svh"
// ************************************************************
// one-millisecond tick from the system clock
// ************************************************************
module bco_ms_timer #(
  parameter int TICK_CYCLES = `BCO_TICK_CYCLES
) (
  input  wire logic CLOCK,
  input  wire logic RST,
  output logic      TICK
);
  logic [23:0] count;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      count <= 24'h00_0000;
      TICK  <= 1'b0;
    end else if (count == 24'(TICK_CYCLES - 1)) begin
      count <= 24'h00_0000;
      TICK  <= 1'b1;
    end else begin
      count <= count + 24'h00_0001;
      TICK  <= 1'b0;
    end
  end
endmodule // bco_ms_timer

// ==== bco_breaker_out.sv ====
// What this block does
// - accepted open command drives off pulse for configured duration
// - accepted close command drives on pulse for configured duration
// - sync-ok false for whole wait limit after close triggers sync switch
// - each breaker operation gives a 150 ms activity pulse
// - status change without command or external indication flags unexpected
// - closed output is filtered closed status
// - opened output is filtered open status
// - counter increments when activity pulse goes active
// - operator reset clears counter at any time
// - state change raises event carrying one of four states
// - operate command off or on becomes open or close pulse
// - pulse duration 50 to 1000 ms, default 300 ms
// - confirmed switching ends pulse early, never before 100 ms
// - zero sync-switch limit never raises sync trigger
// - state from closed and open inputs: mid, off, on, bad
`timescale 1ns/1ps
`include "bco_params.svh"
module bco_breaker_out #(
  parameter int TICK_CYCLES = `BCO_TICK_CYCLES,
  parameter int CNT_W       = 32,
  parameter int FILT_MS     = `BCO_FILT_DEF_MS
) (
  input  wire logic                CLOCK,
  input  wire logic                RST,
  input  wire logic                LOCAL_ENABLE,
  input  wire logic                REMOTE_ENABLE,
  input  wire logic                ENABLE_OFF,
  input  wire logic                ENABLE_ON,
  input  wire logic                BLOCK_OPERATION,
  input  wire logic                SYNC_CHECK_USED,
  input  wire logic                SYNCHRONISM_GOOD,
  input  wire logic                OPEN_STATUS_INPUT,
  input  wire logic                CLOSED_STATUS_INPUT,
  input  wire logic                EXTERNAL_SWITCH_INDICATION,
  input  wire bco_pkg::bco_oper_t  BREAKER_COMMAND_CHANNEL,
  input  wire logic [15:0]         PULSE_MS,
  input  wire logic [15:0]         SYNC_WAIT_LIMIT,
  input  wire logic [15:0]         SYNC_SWITCH_LIMIT,
  input  wire logic                COUNTER_RESET,
  output logic                     OFF_COMMAND_PULSE,
  output logic                     ON_COMMAND_PULSE,
  output logic                     SYNC_SWITCH_TRIGGER,
  output logic                     OPERATION_PULSE,
  output logic                     UNEXPECTED_STATE_CHANGE,
  output logic                     CLOSED,
  output logic                     OPENED,
  output logic [CNT_W-1:0]         OPERATION_COUNT,
  output bco_pkg::bco_event_t      STATE_EVENT
);
  // ************************************************************
  // timebase and input synchronisers
  // ************************************************************
  logic tick;

  bco_ms_timer #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .CLOCK (CLOCK),
    .RST   (RST),
    .TICK  (tick)
  );

  logic [2:0] raw_in;
  logic       open_in;
  logic       closed_in;
  logic       ext_in;

  assign raw_in = {EXTERNAL_SWITCH_INDICATION, CLOSED_STATUS_INPUT,
                   OPEN_STATUS_INPUT};

  // three stages per pin; a change counts once stages two and three agree
  for (genvar g = 0; g < 3; g++) begin : g_sync
    logic [2:0] stage;
    logic       clean;

    always_ff @(posedge CLOCK) begin
      if (RST)
        stage <= 3'h0;
      else
        stage <= {stage[1:0], raw_in[g]};
    end

    always_ff @(posedge CLOCK) begin
      if (RST)
        clean <= 1'b0;
      else if (stage[1] == stage[2])
        clean <= stage[2];
    end
  end

  assign open_in   = g_sync[0].clean;
  assign closed_in = g_sync[1].clean;
  assign ext_in    = g_sync[2].clean;

  // ************************************************************
  // state encoding, filtered outputs and state event
  // ************************************************************
  bco_pkg::bco_state_t state_now;
  bco_pkg::bco_state_t state_seen;
  logic [15:0]         filt_ms;
  logic                state_changed;

  assign state_now = bco_pkg::bco_state_t'({closed_in, open_in});
  assign state_changed = (state_now != state_seen);

  // status must hold steady FILT_MS before the filtered outputs follow
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_seen <= bco_pkg::BCO_ST_MID;
      filt_ms    <= `BCO_MS_ZERO;
      CLOSED     <= 1'b0;
      OPENED     <= 1'b0;
    end else begin
      state_seen <= state_now;
      if (state_changed)
        filt_ms <= `BCO_MS_ZERO;
      else if (tick && filt_ms != 16'(FILT_MS))
        filt_ms <= filt_ms + `BCO_MS_ONE;
      if (filt_ms == 16'(FILT_MS) && !state_changed) begin
        CLOSED <= (state_now == bco_pkg::BCO_ST_ON);
        OPENED <= (state_now == bco_pkg::BCO_ST_OFF);
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST)
      STATE_EVENT <= '{strobe: 1'b0, value: bco_pkg::BCO_ST_MID};
    else
      STATE_EVENT <= '{strobe: state_changed, value: state_now};
  end

  // ************************************************************
  // command acceptance and pulse timing
  // ************************************************************
  logic        authorised;
  logic        want_off;
  logic        want_on;
  logic        sync_wait;
  logic [15:0] sync_ms;
  logic [15:0] sw_ms;
  logic        sw_wait;
  logic [15:0] pulse_ms;
  logic [15:0] pulse_len;
  logic        cmd_recent;

  assign authorised = (LOCAL_ENABLE || REMOTE_ENABLE) && !BLOCK_OPERATION;
  assign want_off = BREAKER_COMMAND_CHANNEL.valid &&
                    !BREAKER_COMMAND_CHANNEL.value;
  assign want_on  = BREAKER_COMMAND_CHANNEL.valid &&
                    BREAKER_COMMAND_CHANNEL.value;
  // out-of-range settings are clamped rather than refused
  assign pulse_len = (PULSE_MS < `BCO_PULSE_MIN_MS) ? `BCO_PULSE_MIN_MS :
                     (PULSE_MS > `BCO_PULSE_MAX_MS) ? `BCO_PULSE_MAX_MS :
                     PULSE_MS;

  logic busy;
  logic go_off;
  logic go_on;
  logic close_ok;
  logic confirmed;

  assign busy = OFF_COMMAND_PULSE || ON_COMMAND_PULSE || sync_wait || sw_wait;
  assign go_off = !busy && want_off && authorised && ENABLE_OFF;
  assign close_ok = !SYNC_CHECK_USED || SYNCHRONISM_GOOD;
  assign go_on = (!busy && want_on && authorised && ENABLE_ON && close_ok) ||
                 (sync_wait && SYNCHRONISM_GOOD);
  assign confirmed = (OFF_COMMAND_PULSE && state_now == bco_pkg::BCO_ST_OFF) ||
                     (ON_COMMAND_PULSE && state_now == bco_pkg::BCO_ST_ON);

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      OFF_COMMAND_PULSE <= 1'b0;
      ON_COMMAND_PULSE  <= 1'b0;
      pulse_ms          <= `BCO_MS_ZERO;
    end else if (go_off || go_on) begin
      OFF_COMMAND_PULSE <= go_off;
      ON_COMMAND_PULSE  <= go_on;
      pulse_ms          <= `BCO_MS_ZERO;
    end else if (OFF_COMMAND_PULSE || ON_COMMAND_PULSE) begin
      if (pulse_ms >= pulse_len ||
          (confirmed && pulse_ms >= `BCO_EARLY_MIN_MS)) begin
        OFF_COMMAND_PULSE <= 1'b0;
        ON_COMMAND_PULSE  <= 1'b0;
      end else if (tick) begin
        pulse_ms <= pulse_ms + `BCO_MS_ONE;
      end
    end
  end

  // ************************************************************
  // synchro-check wait and synchro-switch trigger
  // ************************************************************
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      sync_wait <= 1'b0;
      sync_ms   <= `BCO_MS_ZERO;
    end else if (!busy && want_on && authorised && ENABLE_ON &&
                 !close_ok) begin
      sync_wait <= 1'b1;
      sync_ms   <= `BCO_MS_ZERO;
    end else if (sync_wait) begin
      if (SYNCHRONISM_GOOD || sync_ms >= SYNC_WAIT_LIMIT)
        sync_wait <= 1'b0;
      else if (tick)
        sync_ms <= sync_ms + `BCO_MS_ONE;
    end
  end

  // trigger stays high while waiting for the synchro-switch to close
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      sw_wait             <= 1'b0;
      sw_ms               <= `BCO_MS_ZERO;
      SYNC_SWITCH_TRIGGER <= 1'b0;
    end else if (sync_wait && !SYNCHRONISM_GOOD &&
                 sync_ms >= SYNC_WAIT_LIMIT &&
                 SYNC_SWITCH_LIMIT != `BCO_MS_ZERO) begin
      sw_wait             <= 1'b1;
      sw_ms               <= `BCO_MS_ZERO;
      SYNC_SWITCH_TRIGGER <= 1'b1;
    end else if (sw_wait) begin
      if (sw_ms >= SYNC_SWITCH_LIMIT || state_now == bco_pkg::BCO_ST_ON) begin
        sw_wait             <= 1'b0;
        SYNC_SWITCH_TRIGGER <= 1'b0;
      end else if (tick) begin
        sw_ms <= sw_ms + `BCO_MS_ONE;
      end
    end
  end

  // ************************************************************
  // operation pulse, counter and unexpected change
  // ************************************************************
  logic [15:0] oper_ms;
  logic        operation;

  assign operation = state_changed &&
    (state_now == bco_pkg::BCO_ST_ON || state_now == bco_pkg::BCO_ST_OFF);

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      OPERATION_PULSE <= 1'b0;
      oper_ms         <= `BCO_MS_ZERO;
    end else if (operation) begin
      OPERATION_PULSE <= 1'b1;
      oper_ms         <= `BCO_MS_ZERO;
    end else if (OPERATION_PULSE) begin
      if (oper_ms >= `BCO_OPER_MS)
        OPERATION_PULSE <= 1'b0;
      else if (tick)
        oper_ms <= oper_ms + `BCO_MS_ONE;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST || COUNTER_RESET)
      OPERATION_COUNT <= '0;
    else if (operation && !OPERATION_PULSE &&
             OPERATION_COUNT != {CNT_W{1'b1}})
      OPERATION_COUNT <= OPERATION_COUNT + CNT_W'(1);
  end

  // a command is "recent" while its off or on pulse runs or the synchro-switch wait lasts
  assign cmd_recent = OFF_COMMAND_PULSE || ON_COMMAND_PULSE || sw_wait;

  always_ff @(posedge CLOCK) begin
    if (RST)
      UNEXPECTED_STATE_CHANGE <= 1'b0;
    else if (operation)
      UNEXPECTED_STATE_CHANGE <= !cmd_recent && !ext_in;
  end
endmodule // bco_breaker_out

// ==== bco_breaker_out_props.sv ====
`timescale 1ns/1ps
// ****
// port checker
// ****
module bco_breaker_out_props #(
  parameter int TICK_CYCLES = 10,
  parameter int CNT_W       = 32
) (
  input wire logic                CLOCK,
  input wire logic                RST,
  input wire logic                ENABLE_OFF,
  input wire logic                BLOCK_OPERATION,
  input wire logic                SYNCHRONISM_GOOD,
  input wire bco_pkg::bco_oper_t  BREAKER_COMMAND_CHANNEL,
  input wire logic [15:0]         SYNC_SWITCH_LIMIT,
  input wire logic                COUNTER_RESET,
  input wire logic                OFF_COMMAND_PULSE,
  input wire logic                ON_COMMAND_PULSE,
  input wire logic                SYNC_SWITCH_TRIGGER,
  input wire logic                OPERATION_PULSE,
  input wire logic [CNT_W-1:0]    OPERATION_COUNT,
  input wire bco_pkg::bco_event_t STATE_EVENT
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  int   op_len;
  int   cmd_len;
  logic cmd_any;
  assign cmd_any = OFF_COMMAND_PULSE | ON_COMMAND_PULSE;
  always_ff @(posedge CLOCK) begin
    op_len <= (RST || !OPERATION_PULSE) ? 0 : op_len + 1;
  end
  always_ff @(posedge CLOCK) begin
    cmd_len <= (RST || !cmd_any) ? 0 : cmd_len + 1;
  end
  a_off_cause: assert property ($rose(OFF_COMMAND_PULSE) |->
    $past(BREAKER_COMMAND_CHANNEL.valid && !BREAKER_COMMAND_CHANNEL.value
    && ENABLE_OFF && !BLOCK_OPERATION)) else $error("off pulse uncaused");
  a_pulse_span: assert property ($fell(cmd_any) |->
    cmd_len >= 49*TICK_CYCLES && cmd_len <= 1001*TICK_CYCLES)
    else $error("command pulse width out of range");
  a_oper_width: assert property ($fell(OPERATION_PULSE) |->
    op_len >= 149*TICK_CYCLES && op_len <= 151*TICK_CYCLES)
    else $error("operation pulse width wrong");
  a_count_step: assert property (!$stable(OPERATION_COUNT) |->
    OPERATION_COUNT == $past(OPERATION_COUNT) + 1 || OPERATION_COUNT == 0)
    else $error("counter jumped");
  a_count_clear: assert property (COUNTER_RESET |=>
    OPERATION_COUNT == 0) else $error("counter not cleared");
  a_event_once: assert property (STATE_EVENT.strobe |=>
    !STATE_EVENT.strobe) else $error("event strobe too long");
  a_switch_zero: assert property (SYNC_SWITCH_LIMIT == 16'h0000 |->
    !SYNC_SWITCH_TRIGGER) else $error("trigger with zero limit");
  a_trig_cause: assert property ($rose(SYNC_SWITCH_TRIGGER) |->
    !ON_COMMAND_PULSE && !$past(SYNCHRONISM_GOOD))
    else $error("trigger without sync loss");
  c_on: cover property ($rose(ON_COMMAND_PULSE));
  c_off: cover property ($rose(OFF_COMMAND_PULSE));
  c_trig: cover property ($rose(SYNC_SWITCH_TRIGGER));
endmodule // bco_breaker_out_props
bind bco_breaker_out bco_breaker_out_props #(
  .TICK_CYCLES(TICK_CYCLES), .CNT_W(CNT_W)) u_props (.CLOCK, .RST,
  .ENABLE_OFF, .BLOCK_OPERATION, .SYNCHRONISM_GOOD, .BREAKER_COMMAND_CHANNEL,
  .SYNC_SWITCH_LIMIT, .COUNTER_RESET, .OFF_COMMAND_PULSE, .ON_COMMAND_PULSE,
  .SYNC_SWITCH_TRIGGER, .OPERATION_PULSE, .OPERATION_COUNT, .STATE_EVENT);

// ==== bco_breaker_model.sv ====
`timescale 1ns/1ps
// ****
// breaker mechanism: contacts part at once, settle after travel
// ****
module bco_breaker_model (
  input  wire logic clock,
  input  wire logic on_cmd,
  input  wire logic off_cmd,
  input  wire logic slow,
  input  wire logic kick,
  output logic      closed_c,
  output logic      open_c
);
  int   dly;
  logic tgt;
  initial begin
    closed_c = 1'b0;
    open_c = 1'b1;
    tgt = 1'b0;
    dly = 0;
  end
  // kick flips the contacts with no command, as a fault would
  always @(posedge clock) begin
    if (kick) begin
      closed_c <= open_c;
      open_c <= closed_c;
      tgt <= open_c;
    end else if ((on_cmd && !tgt) || (off_cmd && tgt)) begin
      tgt <= on_cmd;
      dly <= slow ? 6000 : 500;
      closed_c <= 1'b0;
      open_c <= 1'b0;
    end else if (dly == 1) begin
      closed_c <= tgt;
      open_c <= !tgt;
      dly <= 0;
    end else if (dly > 1) begin
      dly <= dly - 1;
    end
  end
endmodule // bco_breaker_model

// ==== test_breaker_command_output_logic.sv ====
`timescale 1ns/1ps
// ****
// bench
// ****
module test_breaker_command_output_logic;
  logic CLOCK, RST, LOCAL_ENABLE, REMOTE_ENABLE, ENABLE_OFF, ENABLE_ON;
  logic BLOCK_OPERATION, SYNC_CHECK_USED, SYNCHRONISM_GOOD, COUNTER_RESET;
  logic OPEN_STATUS_INPUT, CLOSED_STATUS_INPUT, EXTERNAL_SWITCH_INDICATION;
  logic OFF_COMMAND_PULSE, ON_COMMAND_PULSE, SYNC_SWITCH_TRIGGER, CLOSED;
  logic OPERATION_PULSE, UNEXPECTED_STATE_CHANGE, OPENED, slow, kick, was_on;
  logic [15:0] PULSE_MS, SYNC_WAIT_LIMIT, SYNC_SWITCH_LIMIT;
  logic [31:0] OPERATION_COUNT;
  bco_pkg::bco_oper_t  BREAKER_COMMAND_CHANNEL;
  bco_pkg::bco_event_t STATE_EVENT;
  bco_pkg::bco_state_t last_ev;
  int n_fail, total_checks, len, k;
  bco_breaker_out #(.TICK_CYCLES(10)) u_dut (.CLOCK, .RST, .LOCAL_ENABLE,
    .REMOTE_ENABLE, .ENABLE_OFF, .ENABLE_ON, .BLOCK_OPERATION,
    .SYNC_CHECK_USED, .SYNCHRONISM_GOOD, .OPEN_STATUS_INPUT,
    .CLOSED_STATUS_INPUT, .EXTERNAL_SWITCH_INDICATION,
    .BREAKER_COMMAND_CHANNEL, .PULSE_MS, .SYNC_WAIT_LIMIT, .SYNC_SWITCH_LIMIT,
    .COUNTER_RESET, .OFF_COMMAND_PULSE, .ON_COMMAND_PULSE,
    .SYNC_SWITCH_TRIGGER, .OPERATION_PULSE, .UNEXPECTED_STATE_CHANGE, .CLOSED,
    .OPENED, .OPERATION_COUNT, .STATE_EVENT);
  bco_breaker_model u_brk (.clock(CLOCK), .on_cmd(ON_COMMAND_PULSE),
    .off_cmd(OFF_COMMAND_PULSE), .slow(slow), .kick(kick),
    .closed_c(CLOSED_STATUS_INPUT), .open_c(OPEN_STATUS_INPUT));
  initial begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK) begin
    if (STATE_EVENT.strobe === 1'b1) last_ev <= STATE_EVENT.value;
  end
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task send(input logic v);
    @(negedge CLOCK) BREAKER_COMMAND_CHANNEL = '{1'b1, v};
    @(negedge CLOCK) BREAKER_COMMAND_CHANNEL = '{1'b0, 1'b0};
  endtask
  // pulse length in cycles, 0 when no pulse starts
  task meas();
    int i;
    len = 0;
    for (i = 0; i < 40 && !(OFF_COMMAND_PULSE | ON_COMMAND_PULSE); i++)
      @(negedge CLOCK);
    was_on = ON_COMMAND_PULSE;
    while ((OFF_COMMAND_PULSE | ON_COMMAND_PULSE) && len < 20000) begin
      len++;
      @(negedge CLOCK);
    end
  endtask
  task end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #(100 * 60000);
    n_fail++;
    end_sim();
  end
  initial begin
    {RST, LOCAL_ENABLE, REMOTE_ENABLE, ENABLE_OFF, ENABLE_ON} = 5'h1F;
    {BLOCK_OPERATION, SYNC_CHECK_USED, COUNTER_RESET, slow, kick} = 5'h00;
    SYNCHRONISM_GOOD = 1'b1;
    EXTERNAL_SWITCH_INDICATION = 1'b0;
    BREAKER_COMMAND_CHANNEL = '0;
    PULSE_MS = 16'h012C;
    SYNC_WAIT_LIMIT = 16'h000A;
    SYNC_SWITCH_LIMIT = 16'h0000;
    repeat (4) @(negedge CLOCK);
    chk("count_in_reset", OPERATION_COUNT, 32'h0000_0000);
    RST = 1'b0;
    repeat (1800) @(negedge CLOCK);
    COUNTER_RESET = 1'b1;
    @(negedge CLOCK) COUNTER_RESET = 1'b0;
    @(negedge CLOCK) chk("count_clear", OPERATION_COUNT, 32'h0);
    send(1'b1);
    meas();
    chk("close_is_on", was_on, 1'b1);
    chk("early_len", len >= 990 && len <= 1010, 1'b1);
    repeat (1600) @(negedge CLOCK);
    chk("closed", CLOSED, 1'b1);
    chk("not_opened", OPENED, 1'b0);
    chk("count_1", OPERATION_COUNT, 32'h1);
    chk("ev_on", last_ev, bco_pkg::BCO_ST_ON);
    chk("commanded", UNEXPECTED_STATE_CHANGE, 1'b0);
    $display("close test done");
    slow = 1'b1;
    PULSE_MS = 16'h0010;
    send(1'b0);
    meas();
    chk("open_is_off", was_on, 1'b0);
    chk("clamp_len", len >= 490 && len <= 510, 1'b1);
    repeat (300) @(negedge CLOCK);
    chk("ev_mid", last_ev, bco_pkg::BCO_ST_MID);
    repeat (7000) @(negedge CLOCK);
    chk("opened", OPENED, 1'b1);
    chk("not_closed", CLOSED, 1'b0);
    chk("ev_off", last_ev, bco_pkg::BCO_ST_OFF);
    chk("count_2", OPERATION_COUNT, 32'h2);
    $display("slow open test done");
    {slow, PULSE_MS} = {1'b0, 16'h012C};
    for (k = 0; k < 3; k++) begin
      {BLOCK_OPERATION, ENABLE_ON} = (k == 0) ? 2'b11 :
                                     (k == 1) ? 2'b00 : 2'b01;
      {LOCAL_ENABLE, REMOTE_ENABLE} = (k == 2) ? 2'b00 : 2'b11;
      send(1'b1);
      meas();
      chk("refused", len, 32'h0);
    end
    {BLOCK_OPERATION, ENABLE_ON, LOCAL_ENABLE, REMOTE_ENABLE} = 4'h7;
    $display("refusal test done");
    {SYNC_CHECK_USED, SYNCHRONISM_GOOD} = 2'b10;
    send(1'b1);
    repeat (300) @(negedge CLOCK);
    chk("no_trigger", SYNC_SWITCH_TRIGGER, 1'b0);
    SYNC_SWITCH_LIMIT = 16'h0014;
    send(1'b1);
    repeat (150) @(negedge CLOCK);
    chk("trigger", SYNC_SWITCH_TRIGGER, 1'b1);
    repeat (300) @(negedge CLOCK);
    chk("trigger_end", SYNC_SWITCH_TRIGGER, 1'b0);
    SYNC_SWITCH_LIMIT = 16'h0000;
    send(1'b1);
    repeat (50) @(negedge CLOCK);
    chk("sync_hold", ON_COMMAND_PULSE, 1'b0);
    SYNCHRONISM_GOOD = 1'b1;
    meas();
    chk("sync_close", was_on, 1'b1);
    repeat (1700) @(negedge CLOCK);
    $display("sync test done");
    for (k = 0; k < 2; k++) begin
      EXTERNAL_SWITCH_INDICATION = k[0];
      @(negedge CLOCK) kick = 1'b1;
      @(negedge CLOCK) kick = 1'b0;
      repeat (20) @(negedge CLOCK);
      chk("oper_on", OPERATION_PULSE, 1'b1);
      repeat (1680) @(negedge CLOCK);
      chk("oper_off", OPERATION_PULSE, 1'b0);
      chk("unexpected", UNEXPECTED_STATE_CHANGE, !k[0]);
      chk("count_kick", OPERATION_COUNT, 32'h4 + k);
    end
    $display("unexpected test done");
    end_sim();
  end
endmodule // test_breaker_command_output_logic
